// *** verilog/wait_ctl_pkg.sv ***
package wait_ctl_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_DMA_WAIT  = 8'h00; // Single-mode DMA wait control
  localparam logic [7:0] OFS_LONG_WAIT = 8'h04; // Long wait and pull-up control
  localparam logic [7:0] OFS_BUS_CTRL  = 8'h08; // Bus control, DRAM enable
  localparam logic [7:0] OFS_STATUS    = 8'h0C; // Cycle engine status

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] RST_DMA_WAIT  = 16'hFFFF; // All areas sample wait
  localparam logic [15:0] RST_LONG_WAIT = 16'hF800; // Pull-up on, 4 long waits
  localparam logic        RST_DRAM_EN   = 1'h0;     // Area 1 plain memory

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_READ_BITS  = 8;  // Read sample bits 15..8
  localparam int POS_WRITE_BITS = 0;  // Write sample bits 7..0
  localparam int POS_PULLUP     = 15; // Wait pin pull-up enable
  localparam int POS_LW02       = 13; // Areas 0 and 2 long wait code
  localparam int POS_LW6        = 11; // Area 6 long wait code
  localparam int POS_DRAM_EN    = 0;  // DRAM space enable in bus control

  // ----------------------------------------
  // State counts and area numbers
  // ----------------------------------------
  localparam logic [2:0] ST_SHORT   = 3'h1; // Fixed single state
  localparam logic [2:0] ST_LONG    = 3'h2; // Long pitch / sampled cycle
  localparam logic [2:0] ST_MUX_IO  = 3'h4; // Multiplexed I/O cycle
  localparam logic [2:0] ST_LW_BASE = 3'h2; // One state plus code plus one
  localparam logic [2:0] AREA_0     = 3'h0;
  localparam logic [2:0] AREA_DRAM  = 3'h1;
  localparam logic [2:0] AREA_2     = 3'h2;
  localparam logic [2:0] AREA_MUX   = 3'h6;

  // ----------------------------------------
  // Bus answers
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] area;    // Target area 7..0
    logic       isWrite; // Memory write when high
    logic       muxIo;   // Access targets multiplexed I/O space
  } dma_req_t;

  typedef enum logic [0:0] {
    T_IDLE = 1'b0,
    T_RUN  = 1'b1
  } timer_state_t;

endpackage : wait_ctl_pkg

// *** verilog/wait_state_timer.sv ***
`timescale 1ns/1ps
module wait_state_timer (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       start,      // Begin a cycle, only while idle
  input  wire logic [2:0] baseStates, // States before wait extension
  input  wire logic       sampleWait, // Honour waitN in last state
  input  wire logic       waitN,      // Active-low wait request
  output logic            busy,       // Cycle in progress
  output logic            done,       // Last state of the cycle
  output logic            extending   // Current state is a wait state
);

  wait_ctl_pkg::timer_state_t state_r; // Engine state
  logic [2:0]                 remain_r; // States left incl. current
  logic                       sample_r; // Latched sample choice
  logic                       lastState; // In final counted state

  // ----------------------------------------
  // Completion decode
  // ----------------------------------------
  assign busy      = (state_r == wait_ctl_pkg::T_RUN);
  assign lastState = busy && (remain_r == 3'h1);
  assign extending = lastState && sample_r && !waitN;
  assign done      = lastState && !extending;

  // ----------------------------------------
  // State counter
  // ----------------------------------------
  // Settings latched at start so a register write mid-cycle is harmless
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r  <= wait_ctl_pkg::T_IDLE;
      remain_r <= 3'h0;
      sample_r <= 1'b0;
    end else begin
      case (state_r)
        wait_ctl_pkg::T_IDLE: begin
          if (start) begin
            state_r  <= wait_ctl_pkg::T_RUN;
            remain_r <= baseStates;
            sample_r <= sampleWait;
          end
        end
        wait_ctl_pkg::T_RUN: begin
          if (done) begin
            state_r <= wait_ctl_pkg::T_IDLE;
          end else if (remain_r > 3'h1) begin
            remain_r <= remain_r - 3'h1;
          end
        end
        default: state_r <= wait_ctl_pkg::T_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_extend_hold;
    @(posedge sys_clk) disable iff (!rstn)
      extending |-> !done ##1 (busy && remain_r == 3'h1);
  endproperty
  a_extend_hold: assert property (p_extend_hold) else $error("wait state lost");

  property p_no_sample;
    @(posedge sys_clk) disable iff (!rstn)
      (busy && !sample_r) |-> !extending;
  endproperty
  a_no_sample: assert property (p_no_sample) else $error("wait honoured while off");

endmodule : wait_state_timer

// *** verilog/dma_wait_state_control.sv ***
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dma_wait_state_control #(
  parameter int ADDR_W = 8, // Byte address width
  parameter int AREAS  = 8  // Address areas served
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic [ADDR_W-1:0]     awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [ADDR_W-1:0]     araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire wait_ctl_pkg::dma_req_t dmaReq,
  input  wire logic                  cycStart,
  output logic                       cycReady,
  output logic                       cycBusy,
  output logic                       cycDone,
  output logic                       cycExtending,
  input  wire logic                  waitN,
  output logic                       waitPullupEn
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (AREAS != 8 || ADDR_W < 8) begin : g_bad_param
    $error("unsupported AREAS or ADDR_W");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [15:0]       dmaWait_r;   // Read bits 15..8, write bits 7..0
  logic [4:0]        longWait_r;  // Stored bits 15..11 only
  logic              dramEn_r;    // Area 1 is DRAM space
  logic              awHeld_r;    // Write address captured
  logic              wHeld_r;     // Write data captured
  logic [ADDR_W-1:0] awAddr_r;    // Captured write address
  logic [31:0]       wData_r;     // Captured write data
  logic [3:0]        wStrb_r;     // Captured byte enables
  logic              bvalid_r;    // Write answer pending
  logic [1:0]        bresp_r;     // Write answer code
  logic              rvalid_r;    // Read answer pending
  logic [1:0]        rresp_r;     // Read answer code
  logic [31:0]       rdata_r;     // Read answer data
  logic [2:0]        curArea_r;   // Area of running cycle
  logic              doWrite;     // Both write halves present
  logic              arFire;      // Read address taken
  logic [AREAS-1:0]  selBits;     // Per-area sample bit for direction
  logic              areaBit;     // Sample bit of requested area
  logic              isDram;      // Request hits DRAM space
  logic              isMux;       // Request hits multiplexed I/O
  logic              isLong;      // Request hits long wait area
  logic [1:0]        lwCode;      // Long wait code for request
  logic [2:0]        baseStates;  // Counted states for request
  logic              sampleWait;  // Wait input honoured
  logic              engStart;    // Accepted cycle request

  // ----------------------------------------
  // Bus handshakes
  // ----------------------------------------
  // One write held at a time; no new halves while the answer waits
  assign awready = !awHeld_r && !bvalid_r;
  assign wready  = !wHeld_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign doWrite = awHeld_r && wHeld_r;
  assign arFire  = arvalid && arready;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;

  // ----------------------------------------
  // Write channel capture
  // ----------------------------------------
  // Address and data may come in either order
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= '0;
      wData_r  <= 32'h0;
      wStrb_r  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= awaddr;
      end else if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end else if (doWrite) begin
        wHeld_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Write answer
  // ----------------------------------------
  // Status is read-only but answers OKAY; unknown offsets get SLVERR
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= wait_ctl_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid_r <= 1'b1;
      case (awAddr_r[7:0])
        wait_ctl_pkg::OFS_DMA_WAIT, wait_ctl_pkg::OFS_LONG_WAIT,
        wait_ctl_pkg::OFS_BUS_CTRL, wait_ctl_pkg::OFS_STATUS: begin
          bresp_r <= wait_ctl_pkg::RESP_OKAY;
        end
        default: bresp_r <= wait_ctl_pkg::RESP_SLVERR;
      endcase
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Only the power-on reset clears these; no other reset reaches them
  // power-on reset only
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dmaWait_r  <= wait_ctl_pkg::RST_DMA_WAIT;
      longWait_r <= wait_ctl_pkg::RST_LONG_WAIT[15:11];
      dramEn_r   <= wait_ctl_pkg::RST_DRAM_EN;
    end else if (doWrite) begin
      case (awAddr_r[7:0])
        wait_ctl_pkg::OFS_DMA_WAIT: begin
          if (wStrb_r[0]) dmaWait_r[7:0] <= wData_r[7:0];
          if (wStrb_r[1]) dmaWait_r[15:8] <= wData_r[15:8];
        end
        wait_ctl_pkg::OFS_LONG_WAIT: begin
          if (wStrb_r[1]) longWait_r <= wData_r[15:11];
        end
        wait_ctl_pkg::OFS_BUS_CTRL: begin
          if (wStrb_r[0]) dramEn_r <= wData_r[wait_ctl_pkg::POS_DRAM_EN];
        end
        default: begin
          // Status and unmapped writes change nothing
        end
      endcase
    end
  end
  assign waitPullupEn = longWait_r[wait_ctl_pkg::POS_PULLUP - 11];

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  // Answer one cycle after the address is taken
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= wait_ctl_pkg::RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (arFire) begin
      rvalid_r <= 1'b1;
      rresp_r  <= wait_ctl_pkg::RESP_OKAY;
      case (araddr[7:0])
        wait_ctl_pkg::OFS_DMA_WAIT:  rdata_r <= {16'h0, dmaWait_r};
        wait_ctl_pkg::OFS_LONG_WAIT: rdata_r <= {16'h0, longWait_r, 11'h0};
        wait_ctl_pkg::OFS_BUS_CTRL:  rdata_r <= {31'h0, dramEn_r};
        wait_ctl_pkg::OFS_STATUS:    rdata_r <= {27'h0, curArea_r, cycExtending, cycBusy};
        default: begin
          rdata_r <= 32'h0;
          rresp_r <= wait_ctl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Per-area sample bit and cycle length
  // ----------------------------------------
  // reads use bits 15..8, writes use bits 7..0
  for (genvar i = 0; i < AREAS; i++) begin : g_area
    assign selBits[i] = dmaReq.isWrite ? dmaWait_r[wait_ctl_pkg::POS_WRITE_BITS + i]
                                       : dmaWait_r[wait_ctl_pkg::POS_READ_BITS + i];
  end
  assign areaBit = selBits[dmaReq.area];

  // Multiplexed I/O exists only in area 6; the flag elsewhere is ignored
  always_comb begin
    isMux  = dmaReq.muxIo && (dmaReq.area == wait_ctl_pkg::AREA_MUX);
    isDram = (dmaReq.area == wait_ctl_pkg::AREA_DRAM) && dramEn_r;
    isLong = (dmaReq.area == wait_ctl_pkg::AREA_0) || (dmaReq.area == wait_ctl_pkg::AREA_2) ||
             (dmaReq.area == wait_ctl_pkg::AREA_MUX);
    lwCode = longWait_r[wait_ctl_pkg::POS_LW02 - 11 +: 2];
    if (dmaReq.area == wait_ctl_pkg::AREA_MUX) begin
      lwCode = longWait_r[wait_ctl_pkg::POS_LW6 - 11 +: 2];
    end
    sampleWait = areaBit;
    if (isMux) begin
      baseStates = wait_ctl_pkg::ST_MUX_IO;
      sampleWait = 1'b1;
    end else if (isDram) begin
      baseStates = areaBit ? wait_ctl_pkg::ST_LONG : wait_ctl_pkg::ST_SHORT;
    end else if (isLong) begin
      baseStates = wait_ctl_pkg::ST_LW_BASE + {1'b0, lwCode};
    end else begin
      baseStates = areaBit ? wait_ctl_pkg::ST_LONG : wait_ctl_pkg::ST_SHORT;
    end
  end

  // ----------------------------------------
  // Cycle engine
  // ----------------------------------------
  // A request offered while busy simply waits for cycReady
  assign cycReady = !cycBusy;
  assign engStart = cycStart && cycReady;
  wait_state_timer u_timer (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .start      (engStart),
    .baseStates (baseStates),
    .sampleWait (sampleWait),
    .waitN      (waitN),
    .busy       (cycBusy),
    .done       (cycDone),
    .extending  (cycExtending)
  );
  // Area of running cycle, for status
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      curArea_r <= 3'h0;
    end else if (engStart) begin
      curArea_r <= dmaReq.area;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_one_state;
    ##1 cycDone;
  endsequence
  sequence s_two_states;
    ##1 !cycDone ##1 (cycDone || cycExtending);
  endsequence
  sequence s_five_states;
    ##1 !cycDone [*4] ##1 cycDone;
  endsequence
  sequence s_mux_states;
    ##1 !cycDone [*3] ##1 (cycDone || cycExtending);
  endsequence
  property p_plain_short;
    (engStart && !isMux && !isDram && !isLong && !areaBit) |-> s_one_state;
  endproperty
  a_plain_short: assert property (p_plain_short) else $error("short cycle not one state");
  property p_plain_long;
    (engStart && !isMux && !isDram && !isLong && areaBit) |-> s_two_states;
  endproperty
  a_plain_long: assert property (p_plain_long) else $error("sampled cycle not two states");
  property p_long_wait;
    (engStart && !isMux && isLong && !areaBit && dmaReq.area != wait_ctl_pkg::AREA_MUX &&
     longWait_r[3:2] == 2'h3) |-> s_five_states;
  endproperty
  a_long_wait: assert property (p_long_wait) else $error("long wait count wrong");
  property p_dram_short;
    (engStart && dmaReq.area == wait_ctl_pkg::AREA_DRAM && dramEn_r && !areaBit) |-> s_one_state;
  endproperty
  a_dram_short: assert property (p_dram_short) else $error("short pitch wrong");
  property p_mux_io;
    (engStart && isMux) |-> s_mux_states;
  endproperty
  a_mux_io: assert property (p_mux_io) else $error("mux I/O cycle wrong");
  property p_pullup;
    (doWrite && awAddr_r[7:0] == wait_ctl_pkg::OFS_LONG_WAIT && wStrb_r[1])
      |=> waitPullupEn == $past(wData_r[15]);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not following write");
  property p_reserved_zero;
    (arFire && araddr[7:0] == wait_ctl_pkg::OFS_LONG_WAIT) |=> rvalid && rdata[10:0] == 11'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");
  property p_write_answer;
    doWrite |=> bvalid && !awready && !wready;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer missing");
endmodule : dma_wait_state_control

// *** dv/wait_device_model.sv ***
`timescale 1ns/1ps
module wait_device_model (
  input  wire logic       sys_clk,      // System clock
  input  wire logic       rstn,         // Power-on reset, active low
  input  wire logic       cycBusy,      // Cycle in progress
  input  wire logic       cycExtending, // Current state is a wait state
  input  wire logic [3:0] holdCnt,      // Wait states to request
  output logic            waitN         // Wait request, active low
);
  // ----------------------------------------
  // Wait request source
  // ----------------------------------------
  logic [3:0] extCnt_r; // Wait states granted so far

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      extCnt_r <= 4'h0;
    end else if (!cycBusy) begin
      extCnt_r <= 4'h0;
    end else if (cycExtending) begin
      extCnt_r <= extCnt_r + 4'h1;
    end
  end

  // hold low per wait
  // Released line sits at the pull-up level
  assign waitN = !(cycBusy && (extCnt_r < holdCnt));
endmodule : wait_device_model

// *** dv/dma_wait_state_control_bench.sv ***
`timescale 1ns/1ps
module dma_wait_state_control_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                   sys_clk, rstn, awvalid, wvalid, bready, arvalid, rready, cycStart;
  logic                   awready, wready, bvalid, arready, rvalid, cycReady, cycBusy, cycDone;
  logic                   cycExtending, waitN, waitPullupEn;
  logic [7:0]             awaddr, araddr;     // Byte addresses
  logic [31:0]            wdata, rdata;       // Bus data
  logic [3:0]             wstrb, holdCnt;     // Strobes, requested waits
  logic [1:0]             bresp, rresp;       // Bus answers
  wait_ctl_pkg::dma_req_t dmaReq;             // Cycle request payload
  int                     failures, comparisons;

  dma_wait_state_control u_dut (.sys_clk(sys_clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .dmaReq(dmaReq), .cycStart(cycStart),
    .cycReady(cycReady), .cycBusy(cycBusy), .cycDone(cycDone), .cycExtending(cycExtending),
    .waitN(waitN), .waitPullupEn(waitPullupEn));

  wait_device_model u_dev (.sys_clk(sys_clk), .rstn(rstn), .cycBusy(cycBusy),
    .cycExtending(cycExtending), .holdCnt(holdCnt), .waitN(waitN));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Both halves offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] expResp);
    logic       tA, tW, tB;
    logic [1:0] r;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    tB = 1'b0;
    r  = 2'h1;
    // No cycle limit here: only the watchdog ends a missing answer
    while (!tB) begin
      #1;
      tA = awvalid && awready;
      tW = wvalid && wready;
      tB = bvalid && bready;
      r  = bresp;
      @(posedge sys_clk);
      if (tA) awvalid <= 1'b0;
      if (tW) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    check({30'h0, r}, {30'h0, expResp});
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] expD, input logic [1:0] expResp);
    logic        tA, tR;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    tR = 1'b0;
    d  = 32'hDEADBEEF;
    r  = 2'h1;
    while (!tR) begin
      #1;
      tA = arvalid && arready;
      tR = rvalid && rready;
      d  = rdata;
      r  = rresp;
      @(posedge sys_clk);
      if (tA) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    check(d, expD);
    check({30'h0, r}, {30'h0, expResp});
  endtask : axi_read

  // Counts states from accept to the done state; the first state follows the accept edge
  task automatic run_cycle(input logic [2:0] ar, input logic wr, input logic mux, input int hold, input int expN);
    int k;
    k = 1;
    @(posedge sys_clk);
    dmaReq   <= '{area: ar, isWrite: wr, muxIo: mux};
    holdCnt  <= hold[3:0];
    cycStart <= 1'b1;
    @(posedge sys_clk);
    cycStart <= 1'b0;
    #1;
    while (cycDone !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check(k, expN);
    check({31'h0, cycBusy}, 32'h1);
  endtask : run_cycle

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    axi_read(wait_ctl_pkg::OFS_DMA_WAIT, 32'h0000FFFF, wait_ctl_pkg::RESP_OKAY);
    axi_read(wait_ctl_pkg::OFS_LONG_WAIT, 32'h0000F800, wait_ctl_pkg::RESP_OKAY);
    axi_read(wait_ctl_pkg::OFS_BUS_CTRL, 32'h00000000, wait_ctl_pkg::RESP_OKAY);
    check({31'h0, waitPullupEn}, 32'h1);
    // Software keeps bits 10..0 at zero on every write
    axi_write(wait_ctl_pkg::OFS_LONG_WAIT, 32'h00000000, wait_ctl_pkg::RESP_OKAY);
    axi_read(wait_ctl_pkg::OFS_LONG_WAIT, 32'h00000000, wait_ctl_pkg::RESP_OKAY);
    check({31'h0, waitPullupEn}, 32'h0);
    axi_write(wait_ctl_pkg::OFS_LONG_WAIT, 32'h0000F800, wait_ctl_pkg::RESP_OKAY);
    check({31'h0, waitPullupEn}, 32'h1);
    axi_write(wait_ctl_pkg::OFS_LONG_WAIT, 32'h00007800, wait_ctl_pkg::RESP_OKAY);
    axi_read(wait_ctl_pkg::OFS_LONG_WAIT, 32'h00007800, wait_ctl_pkg::RESP_OKAY);
    check({31'h0, waitPullupEn}, 32'h0);
    axi_write(8'h10, 32'h00001234, wait_ctl_pkg::RESP_SLVERR);
    axi_read(8'h10, 32'h00000000, wait_ctl_pkg::RESP_SLVERR);
  endtask : t_regs

  // Each code of both long wait fields, wait sampled
  task automatic t_codes();
    for (int c = 0; c < 4; c++) begin
      axi_write(wait_ctl_pkg::OFS_LONG_WAIT, {16'h0, 1'b1, c[1:0], 2'(3 - c), 11'h0}, wait_ctl_pkg::RESP_OKAY);
      run_cycle(wait_ctl_pkg::AREA_0, 1'b0, 1'b0, 1, 3 + c);
      run_cycle(wait_ctl_pkg::AREA_2, 1'b1, 1'b0, 1, 3 + c);
      run_cycle(wait_ctl_pkg::AREA_MUX, 1'b0, 1'b0, 1, 6 - c);
    end
  endtask : t_codes

  task automatic t_sampling();
    axi_write(wait_ctl_pkg::OFS_DMA_WAIT, 32'h00000000, wait_ctl_pkg::RESP_OKAY);
    run_cycle(3'h3, 1'b0, 1'b0, 2, 1);
    run_cycle(3'h7, 1'b1, 1'b0, 2, 1);
    run_cycle(wait_ctl_pkg::AREA_MUX, 1'b1, 1'b1, 2, 6);
    run_cycle(wait_ctl_pkg::AREA_0, 1'b0, 1'b0, 2, 5);
    axi_write(wait_ctl_pkg::OFS_DMA_WAIT, 32'h0000FFFF, wait_ctl_pkg::RESP_OKAY);
    run_cycle(3'h4, 1'b0, 1'b0, 2, 4);
    run_cycle(3'h5, 1'b1, 1'b0, 0, 2);
    run_cycle(wait_ctl_pkg::AREA_MUX, 1'b0, 1'b1, 0, 4);
  endtask : t_sampling

  // One-hot bit per area 1, 3, 4, 5 and 7 proves mapping and read/write split
  task automatic t_bits();
    for (int a = 0; a < 8; a++) begin
      if (a != 0 && a != 2 && a != 6) begin
        axi_write(wait_ctl_pkg::OFS_DMA_WAIT, 32'h1 << a, wait_ctl_pkg::RESP_OKAY);
        run_cycle(3'(a), 1'b1, 1'b0, 1, 3);
        run_cycle(3'(a), 1'b0, 1'b0, 1, 1);
        axi_write(wait_ctl_pkg::OFS_DMA_WAIT, 32'h100 << a, wait_ctl_pkg::RESP_OKAY);
        run_cycle(3'(a), 1'b0, 1'b0, 1, 3);
        run_cycle(3'(a), 1'b1, 1'b0, 1, 1);
      end
    end
  endtask : t_bits

  task automatic t_dram();
    axi_write(wait_ctl_pkg::OFS_BUS_CTRL, 32'h00000001, wait_ctl_pkg::RESP_OKAY);
    axi_read(wait_ctl_pkg::OFS_BUS_CTRL, 32'h00000001, wait_ctl_pkg::RESP_OKAY);
    axi_write(wait_ctl_pkg::OFS_DMA_WAIT, 32'h00000000, wait_ctl_pkg::RESP_OKAY);
    run_cycle(wait_ctl_pkg::AREA_DRAM, 1'b0, 1'b0, 1, 1);
    axi_write(wait_ctl_pkg::OFS_DMA_WAIT, 32'h0000FFFF, wait_ctl_pkg::RESP_OKAY);
    run_cycle(wait_ctl_pkg::AREA_DRAM, 1'b1, 1'b0, 1, 3);
    // Status keeps the area of the last cycle, engine idle
    axi_read(wait_ctl_pkg::OFS_STATUS, 32'h00000004, wait_ctl_pkg::RESP_OKAY);
  endtask : t_dram

  // ----------------------------------------
  // Clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, cycStart} = 7'h00;
    {awaddr, araddr, wdata, wstrb, holdCnt} = 56'h0F0;
    dmaReq = '0;
    failures = 0;
    comparisons = 0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_codes();
    t_sampling();
    t_bits();
    t_dram();
    complete_run();
  end

  // Whole run is a few hundred cycles
  initial begin
    #200000;
    failures++;
    complete_run();
  end
endmodule : dma_wait_state_control_bench
